// ---- logic/irq_standby_regs.vh ----
// Purpose: Constants for the priority interrupt and standby controller.
// Assumes: Included by the controller, the property module and the bench.
// Notes:   Vector slots are numbered in ascending vector address order.
`ifndef IRQ_STANDBY_REGS_VH
`define IRQ_STANDBY_REGS_VH

// Priority level codes, top above middle above base.
`define LVL_NONE   2'h0
`define LVL_BASE   2'h1
`define LVL_MID    2'h2
`define LVL_TOP    2'h3

// Standby state codes.
`define SB_RUN     2'h0
`define SB_IDLE    2'h1
`define SB_DEEP    2'h2
`define SB_XTAL    2'h3

// Source and vector counts.
`define NUM_SRC    17
`define NUM_VEC    10

// Source bit positions.
`define SRC_EXT0   0
`define SRC_EXT1   1
`define SRC_EXT2   2
`define SRC_T0L    3
`define SRC_EXT4   4
`define SRC_EXT3   5
`define SRC_EXT5   6
`define SRC_BT     7
`define SRC_T0H    8
`define SRC_T1L    9
`define SRC_T1H    10
`define SRC_SIO    11
`define SRC_ADC    12
`define SRC_T6     13
`define SRC_T7     14
`define SRC_PWM    15
`define SRC_PORT0  16

// Base vector address and spacing between vector entries.
`define VEC_BASE   16'h0003
`define VEC_STEP   16'h0008

`endif

// ---- logic/priority_interrupt_standby_wake.v ----
// Purpose: Three-level nesting interrupt arbiter with standby wake logic.
// Assumes: Sources are synchronous to mclk; the reset pin is not.
// Notes:   Vector 6 has no source and never wins arbitration.
// Function
// - Three nested levels are supported, top above middle above base.
// - A request at or below the level in service is refused.
// - Of simultaneous requests the highest level wins.
// - Among equal levels the smallest vector address wins.
// - Seventeen sources are gathered onto shared vector entries.
// - Idle stops execution only and keeps all oscillators running.
// - Idle ends on reset pin, watchdog or undervolt reset, or any enabled irq.
// - Deep hold stops execution, peripherals and all oscillators.
// - Deep hold ends on resets, external irqs 0,1,2,4,5 or port zero.
// - External irqs zero and one wake a hold only when level detected.
// - Crystal hold keeps only the base timer and crystal state.
// - Crystal hold also ends on base timer; needs crystal selected.
`include "irq_standby_regs.vh"

module priority_interrupt_standby_wake #(
    parameter NSRC = `NUM_SRC,
    parameter NVEC = `NUM_VEC
) (
    // Clock and reset.
    input  wire              mclk,
    input  wire              sys_rst,
    // Interrupt sources, level per vector as two bits each.
    input  wire [NSRC-1:0]   src_req,
    input  wire [NSRC-1:0]   src_en,
    input  wire [2*NVEC-1:0] vec_level,
    input  wire              ext_irq_zero_lvl,
    input  wire              ext_irq_one_lvl,
    // Core handshake.
    input  wire              irq_ack,
    input  wire              irq_ret,
    input  wire              enter_idle,
    input  wire              enter_deep,
    input  wire              enter_xtal,
    input  wire              xtal_selected,
    input  wire              xtal_running,
    // Reset events.
    input  wire              reset_pin_n,
    input  wire              wdt_reset,
    input  wire              undervolt_reset,
    // Core side outputs.
    output reg               irq_valid_r,
    output reg  [15:0]       irq_vector_r,
    output reg  [1:0]        irq_level_r,
    output reg  [1:0]        active_level_r,
    // Standby control outputs.
    output reg  [1:0]        standby_r,
    output reg               cpu_run_r,
    output reg               periph_run_r,
    output reg               base_timer_run_r,
    output reg               ceramic_osc_en_r,
    output reg               resistor_cap_osc_en_r,
    output reg               xtal_osc_en_r
);

    // Pending flags and the stack of levels in service.
    reg  [NSRC-1:0] pend_r;
    reg  [2:0]      svc_r;
    reg  [1:0]      sb_nxt;
    reg  [1:0]      best_lvl;
    reg  [3:0]      best_vec;
    reg  [NVEC-1:0] vec_req;
    reg             xtal_keep_r;
    integer         v;

    // Map a source bit onto its vector slot.
    function [3:0] src_vec;
        input integer s;
        begin
            case (s)
                `SRC_EXT0:                      src_vec = 4'h0;
                `SRC_EXT1:                      src_vec = 4'h1;
                `SRC_EXT2, `SRC_T0L, `SRC_EXT4: src_vec = 4'h2;
                `SRC_EXT3, `SRC_EXT5, `SRC_BT:  src_vec = 4'h3;
                `SRC_T0H:                       src_vec = 4'h4;
                `SRC_T1L, `SRC_T1H:             src_vec = 4'h5;
                `SRC_SIO:                       src_vec = 4'h7;
                `SRC_PORT0:                     src_vec = 4'h9;
                default:                        src_vec = 4'h8;
            endcase
        end
    endfunction

    // Level a vector may take: top only for slots 0 and 1.
    function [1:0] eff_lvl;
        input [3:0] vec;
        input [1:0] cfg;
        begin
            if (cfg == `LVL_TOP && vec > 4'h1)
                eff_lvl = `LVL_MID;
            else if (cfg == `LVL_NONE)
                eff_lvl = `LVL_BASE;
            else
                eff_lvl = cfg;
        end
    endfunction

    // Highest level currently in service.
    wire [1:0] svc_lvl = svc_r[2] ? `LVL_TOP :
                         svc_r[1] ? `LVL_MID :
                         svc_r[0] ? `LVL_BASE : `LVL_NONE;

    // gather sources
    // Sources sharing an entry are ORed onto one vector request.
    integer s;
    always @* begin
        vec_req = {NVEC{1'b0}};
        for (s = 0; s < NSRC; s = s + 1) begin
            if (pend_r[s] && src_en[s])
                vec_req[src_vec(s)] = 1'b1;
        end
    end

    // level first, lowest address
    // Scan downward so the smallest address wins a tie on level.
    always @* begin
        best_lvl = `LVL_NONE;
        best_vec = 4'h0;
        for (v = NVEC - 1; v >= 0; v = v - 1) begin
            if (vec_req[v] &&
                eff_lvl(v[3:0], vec_level[2*v +: 2]) >= best_lvl) begin
                best_lvl = eff_lvl(v[3:0], vec_level[2*v +: 2]);
                best_vec = v[3:0];
            end
        end
    end

    wire grant_ok = (best_lvl != `LVL_NONE) && (best_lvl > svc_lvl);

    // Pending latch; a new event wins over the clear on acceptance.
    // hold refused requests
    integer p;
    always @(posedge mclk) begin
        if (sys_rst) begin
            pend_r <= {NSRC{1'b0}};
        end else begin
            for (p = 0; p < NSRC; p = p + 1) begin
                if (src_req[p])
                    pend_r[p] <= 1'b1;
                else if (irq_ack && irq_valid_r &&
                         src_vec(p) == irq_vector_r[6:3])
                    pend_r[p] <= 1'b0;
            end
        end
    end

    // nesting stack
    // One bit per level; a return clears the highest level in service.
    always @(posedge mclk) begin
        if (sys_rst) begin
            svc_r <= 3'h0;
        end else if (irq_ack && irq_valid_r) begin
            svc_r[irq_level_r - 2'h1] <= 1'b1;
        end else if (irq_ret) begin
            if (svc_r[2])
                svc_r[2] <= 1'b0;
            else if (svc_r[1])
                svc_r[1] <= 1'b0;
            else
                svc_r[0] <= 1'b0;
        end
    end

    // Request to the core; the vector address is base plus step times slot.
    always @(posedge mclk) begin
        if (sys_rst) begin
            irq_valid_r    <= 1'b0;
            irq_vector_r   <= 16'h0000;
            irq_level_r    <= `LVL_NONE;
            active_level_r <= `LVL_NONE;
        end else begin
            irq_valid_r    <= grant_ok && !(irq_ack && irq_valid_r);
            irq_vector_r   <= `VEC_BASE + {best_vec, 3'h0};
            irq_level_r    <= best_lvl;
            active_level_r <= svc_lvl;
        end
    end

    // The reset pin passes three stages; the filtered level moves only
    // once the last two agree, so a one-cycle glitch never wakes a hold.
    reg  [2:0]      pin_sync_r;
    reg             pin_filt_r;
    always @(posedge mclk) begin
        if (sys_rst) begin
            pin_sync_r <= 3'h7;
            pin_filt_r <= 1'b1;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], reset_pin_n};
            if (pin_sync_r[1] == pin_sync_r[2])
                pin_filt_r <= pin_sync_r[2];
        end
    end

    // Wake conditions for each standby state.
    wire any_reset = !pin_filt_r || wdt_reset || undervolt_reset;
    wire any_irq   = |(src_req & src_en);
    wire deep_src  = (src_req[`SRC_EXT0] && ext_irq_zero_lvl) ||
                     (src_req[`SRC_EXT1] && ext_irq_one_lvl) ||
                     src_req[`SRC_EXT2] || src_req[`SRC_EXT4] ||
                     src_req[`SRC_EXT5] ||
                     src_req[`SRC_PORT0];
    wire deep_wake = any_reset || deep_src;
    wire xtal_wake = deep_wake || src_req[`SRC_BT];

    // Standby state machine.
    always @* begin
        case (standby_r)
            `SB_RUN: begin
                if (enter_deep)
                    sb_nxt = `SB_DEEP;
                else if (enter_xtal && xtal_selected)
                    sb_nxt = `SB_XTAL;
                else if (enter_idle)
                    sb_nxt = `SB_IDLE;
                else
                    sb_nxt = `SB_RUN;
            end
            `SB_IDLE: sb_nxt = (any_reset || any_irq) ? `SB_RUN : `SB_IDLE;
            `SB_DEEP: sb_nxt = deep_wake ? `SB_RUN : `SB_DEEP;
            `SB_XTAL: sb_nxt = xtal_wake ? `SB_RUN : `SB_XTAL;
            default:  sb_nxt = `SB_RUN;
        endcase
    end

    // Run enables follow the next state so they change with the state.
    always @(posedge mclk) begin
        if (sys_rst) begin
            standby_r             <= `SB_RUN;
            cpu_run_r             <= 1'b1;
            periph_run_r          <= 1'b1;
            base_timer_run_r      <= 1'b1;
            ceramic_osc_en_r      <= 1'b1;
            resistor_cap_osc_en_r <= 1'b1;
            xtal_osc_en_r         <= 1'b1;
            xtal_keep_r           <= 1'b1;
        end else begin
            standby_r <= sb_nxt;
            cpu_run_r <= (sb_nxt == `SB_RUN);
            periph_run_r          <= (sb_nxt == `SB_RUN) ||
                                     (sb_nxt == `SB_IDLE);
            ceramic_osc_en_r      <= (sb_nxt != `SB_DEEP) &&
                                     (sb_nxt != `SB_XTAL);
            resistor_cap_osc_en_r <= (sb_nxt != `SB_DEEP) &&
                                     (sb_nxt != `SB_XTAL);
            if (standby_r == `SB_RUN && sb_nxt == `SB_XTAL)
                xtal_keep_r <= xtal_running;
            base_timer_run_r <= (sb_nxt != `SB_DEEP);
            if (sb_nxt == `SB_DEEP)
                xtal_osc_en_r <= 1'b0;
            else if (sb_nxt == `SB_XTAL)
                xtal_osc_en_r <= (standby_r == `SB_RUN) ? xtal_running
                                                        : xtal_keep_r;
            else
                xtal_osc_en_r <= 1'b1;
        end
    end

endmodule // priority_interrupt_standby_wake

// ---- tb/irq_props.sv ----
// Purpose: Port-level checks of the interrupt and standby controller.
// Assumes: Bound to the controller; sees a subset of its ports only.
// Notes:   One clock domain, so default clocking and disable are used.
`include "irq_standby_regs.vh"
module irq_props #(parameter NSRC = 17, parameter NVEC = 10) (
    // Controller inputs.
    input wire            mclk, sys_rst, irq_ack, enter_deep, enter_xtal,
    input wire            xtal_selected, reset_pin_n, wdt_reset,
    input wire            undervolt_reset, ext_irq_zero_lvl,
    input wire [NSRC-1:0] src_req,
    // Controller outputs.
    input wire            irq_valid_r, cpu_run_r, periph_run_r,
    input wire            base_timer_run_r, ceramic_osc_en_r,
    input wire            resistor_cap_osc_en_r, xtal_osc_en_r,
    input wire [15:0]     irq_vector_r,
    input wire [1:0]      irq_level_r, active_level_r, standby_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Offer checks; the ack cycle is skipped since the level in service lags.
    offer_above_a: assert property (irq_valid_r && !irq_ack && !$past(irq_ack)
        |-> irq_level_r > active_level_r) else $error("offer not above");
    offer_lvl_a: assert property (irq_valid_r |-> irq_level_r != `LVL_NONE)
        else $error("offer without level");
    vec_map_a: assert property (irq_valid_r |-> irq_vector_r[2:0] == 3'h3
        && irq_vector_r <= 16'h004B && irq_vector_r != 16'h0033)
        else $error("bad vector");
    offer_hold_a: assert property (irq_valid_r && !irq_ack
        |=> irq_valid_r && $stable(irq_vector_r)) else $error("offer lost");
    ack_drop_a: assert property (irq_ack && irq_valid_r |=> !irq_valid_r)
        else $error("offer kept after ack");
    // Standby output patterns.
    idle_run_a: assert property (standby_r == `SB_IDLE |-> !cpu_run_r
        && periph_run_r && ceramic_osc_en_r && resistor_cap_osc_en_r
        && xtal_osc_en_r) else $error("idle outputs");
    deep_stop_a: assert property (standby_r == `SB_DEEP |-> !(cpu_run_r
        | periph_run_r | ceramic_osc_en_r | resistor_cap_osc_en_r
        | xtal_osc_en_r | base_timer_run_r)) else $error("deep outputs");
    xtal_keep_a: assert property (standby_r == `SB_XTAL |-> base_timer_run_r
        && !(cpu_run_r | periph_run_r | resistor_cap_osc_en_r))
        else $error("crystal hold outputs");
    // Wake events and crystal hold entry.
    idle_wake_a: assert property (standby_r == `SB_IDLE && (wdt_reset
        || undervolt_reset) |=> standby_r == `SB_RUN)
        else $error("idle not left");
    pin_wake_a: assert property ((standby_r != `SB_RUN && !reset_pin_n)[*4]
        |-> ##2 standby_r == `SB_RUN) else $error("pin did not wake");
    hold_wake_a: assert property (standby_r[1] && src_req[`SRC_EXT2]
        |=> standby_r == `SB_RUN) else $error("hold not left");
    edge_nowake_a: assert property (standby_r[1] && src_req == 17'h00001
        && !ext_irq_zero_lvl && !wdt_reset && !undervolt_reset
        && $past(reset_pin_n, 3) && $past(reset_pin_n, 4)
        |=> standby_r[1]) else $error("edge input woke hold");
    xtal_need_a: assert property (standby_r == `SB_RUN && enter_xtal
        && !enter_deep && !xtal_selected |=> standby_r != `SB_XTAL)
        else $error("crystal hold without crystal");
    // Main scenarios reached.
    cover property (irq_ack && irq_level_r == `LVL_TOP);
    cover property (standby_r == `SB_DEEP);
    cover property (standby_r == `SB_XTAL);
endmodule // irq_props

bind priority_interrupt_standby_wake irq_props #(.NSRC(NSRC), .NVEC(NVEC))
    i_props (.*);

// ---- tb/core_model.sv ----
// Purpose: Processor core stand-in that takes offered vectors.
// Assumes: Acks only a standing offer, one pulse for each offer.
// Notes:   The bench sets the wait, so acks come promptly or slowly.
module core_model (
    // Clock and reset.
    input  wire       mclk,
    input  wire       sys_rst,
    // Offer in, ack out.
    input  wire       irq_valid_r,
    input  wire [3:0] ack_wait,
    output reg        irq_ack = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [3:0] wait_r = 4'h0;
    // Age the offer; clearing on ack avoids a second ack for one offer.
    always @(posedge mclk) begin
        if (sys_rst || !irq_valid_r || irq_ack) begin
            wait_r  <= 4'h0;
            irq_ack <= 1'b0;
        end else if (wait_r == ack_wait) begin
            irq_ack <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // core_model

// ---- tb/test_priority_interrupt_standby_wake.sv ----
// Purpose: Self-checking bench of the interrupt and standby controller.
// Assumes: The core stand-in acks offers; the bench pulses returns.
// Notes:   Hold runs keep sources disabled so nothing is offered.
`include "irq_standby_regs.vh"
module test_priority_interrupt_standby_wake;
    timeunit 1ns;
    timeprecision 1ps;
    reg mclk = 0, sys_rst = 1, ret = 0, zl = 0, xs = 0, xr = 1;
    reg rpn = 1, wdt = 0, uv = 0, ol = 0;
    reg [2:0] ent = 0;
    reg [3:0] aw = 0;
    reg [16:0] req = 0, en = 17'h1FFFF;
    reg [19:0] lvl = 20'h55555;
    wire valid, ack, cr, pr, br, co, ro, xo;
    wire [15:0] vec;
    wire [1:0] lev, sb;
    integer err_count = 0, tests_run = 0, cyc = 0, k;
    // Slot that each source bit lands on.
    int slots [17] = '{0, 1, 2, 2, 2, 3, 3, 3, 4, 5, 5, 7, 8, 8, 8, 8, 9};
    priority_interrupt_standby_wake i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .src_req(req), .src_en(en), .vec_level(lvl), .ext_irq_zero_lvl(zl),
        .ext_irq_one_lvl(ol), .irq_ack(ack), .irq_ret(ret),
        .enter_idle(ent[0]), .enter_deep(ent[1]), .enter_xtal(ent[2]),
        .xtal_selected(xs), .xtal_running(xr), .reset_pin_n(rpn),
        .wdt_reset(wdt), .undervolt_reset(uv), .irq_valid_r(valid),
        .irq_vector_r(vec), .irq_level_r(lev), .active_level_r(),
        .standby_r(sb), .cpu_run_r(cr), .periph_run_r(pr),
        .base_timer_run_r(br), .ceramic_osc_en_r(co),
        .resistor_cap_osc_en_r(ro), .xtal_osc_en_r(xo));
    core_model i_core (.mclk(mclk), .sys_rst(sys_rst), .irq_valid_r(valid),
        .ack_wait(aw), .irq_ack(ack));
    // Clock, and a ceiling on run length so a hang still reports.
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            test_done;
        end
    end
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string n, input [15:0] e, input [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task pulse(input [16:0] m);
        @(posedge mclk) req <= m;
        @(posedge mclk) req <= 0;
        tick(2);
    endtask
    task rtn;
        @(posedge mclk) ret <= 1;
        @(posedge mclk) ret <= 0;
        #1;
    endtask
    task enter(input [2:0] m);
        @(posedge mclk) ent <= m;
        @(posedge mclk) ent <= 0;
        #1;
    endtask
    // Wait for an offer, check it, then let the core take it.
    task offer(input integer s, input [1:0] l);
        integer i;
        for (i = 0; i < 30 && valid !== 1'b1; i++) tick(1);
        chk("vector", `VEC_BASE + `VEC_STEP * s, vec);
        chk("level", {14'h0, l}, {14'h0, lev});
        for (i = 0; i < 30 && valid !== 1'b0; i++) tick(1);
    endtask
    initial begin
        tick(20);
        chk("reset outputs", 16'h003F, {10'h0, cr, pr, br, co, ro, xo});
        chk("reset offer", 16'h0000, {11'h0, valid, lev, sb});
        chk("reset vector", 16'h0000, vec);
        @(posedge mclk) sys_rst <= 0;
        for (k = 0; k < 17; k++) begin
            pulse(17'h1 << k);
            offer(slots[k], 2'h1);
            rtn;
        end
        @(posedge mclk) lvl <= 20'h55957;
        pulse(17'h1 << `SRC_ADC | 17'h1 << `SRC_T1H);
        offer(5, 2'h2);
        rtn;
        offer(8, 2'h1);
        rtn;
        pulse(17'h1 << `SRC_EXT2 | 17'h1 << `SRC_SIO);
        offer(2, 2'h1);
        @(posedge mclk) aw <= 4'h5;
        pulse(17'h1 << `SRC_T1L);
        offer(5, 2'h2);
        pulse(17'h1 << `SRC_EXT0);
        offer(0, 2'h3);
        tick(8);
        chk("refused", 16'h0, {15'h0, valid});
        rtn;
        rtn;
        tick(8);
        chk("refused", 16'h0, {15'h0, valid});
        rtn;
        offer(7, 2'h1);
        rtn;
        enter(3'h1);
        chk("idle", `SB_IDLE, sb);
        pulse(17'h1 << `SRC_SIO);
        chk("idle wake", `SB_RUN, sb);
        offer(7, 2'h1);
        rtn;
        enter(3'h1);
        @(posedge mclk) wdt <= 1;
        @(posedge mclk) wdt <= 0;
        tick(2);
        chk("idle reset", `SB_RUN, sb);
        @(posedge mclk) en <= 0;
        enter(3'h2);
        chk("deep", `SB_DEEP, sb);
        pulse(17'h1 << `SRC_EXT0);
        chk("edge mode", `SB_DEEP, sb);
        pulse(17'h1 << `SRC_EXT1);
        chk("edge mode one", `SB_DEEP, sb);
        pulse(17'h1 << `SRC_EXT3);
        chk("no wake", `SB_DEEP, sb);
        @(posedge mclk) zl <= 1;
        pulse(17'h1 << `SRC_EXT0);
        chk("level mode", `SB_RUN, sb);
        @(posedge mclk) ol <= 1;
        enter(3'h2);
        pulse(17'h1 << `SRC_EXT1);
        chk("level mode one", `SB_RUN, sb);
        enter(3'h2);
        pulse(17'h1 << `SRC_PORT0);
        chk("port wake", `SB_RUN, sb);
        enter(3'h2);
        @(posedge mclk) uv <= 1;
        @(posedge mclk) uv <= 0;
        tick(2);
        chk("undervolt wake", `SB_RUN, sb);
        enter(3'h2);
        @(posedge mclk) rpn <= 0;
        tick(4);
        @(posedge mclk) rpn <= 1;
        tick(2);
        chk("pin wake", `SB_RUN, sb);
        enter(3'h4);
        chk("no crystal", `SB_RUN, sb);
        @(posedge mclk) xs <= 1;
        enter(3'h4);
        chk("xtal hold", `SB_XTAL, sb);
        chk("xtal outs", 16'h0006, {13'h0, br, xo, ro});
        pulse(17'h1 << `SRC_BT);
        chk("timer wake", `SB_RUN, sb);
        @(posedge mclk) xr <= 0;
        enter(3'h4);
        chk("xtal kept off", 16'h0004, {13'h0, br, xo, ro});
        pulse(17'h1 << `SRC_EXT2);
        chk("hold wake", `SB_RUN, sb);
        test_done;
    end
endmodule // test_priority_interrupt_standby_wake
